//--- logic/rx_bus_host.sv
/*
 Host end of the receive bus: controller with its own register port,
 captures words and flags, reads and writes the serial address register,
 and makes the interface clock when the device FIFO is enabled.
 Assumes a register master on clk with one-cycle strobes.
*/
`timescale 1ns/1ps
module rx_bus_host (
   input  wire logic        clk,
   input  wire logic        rst,
   rx_link_if.host_end      link,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             irq
);
   logic [4:0]  ctrl_q;
   logic [9:0]  sar_wr_q;
   logic [12:0] data_q;
   logic [10:0] sar_rd_q;
   logic [3:0]  status_q;
   logic [3:0]  enable_q;
   logic [31:0] rdata_q;
   logic        irq_q;
   logic [14:0] sync1_q;
   logic [14:0] sync2_q;
   // Idle pull levels, so no false interface clock edge follows reset
   localparam logic [14:0] SYNC_RST = {10'h000, rx_bus_pkg::PIN_PULL, 1'b0};
   logic        lclk_prev_q;
   logic [7:0]  div_cnt_q;
   logic        lclk_q;
   logic [9:0]  bus_o_q;
   logic        bus_oe_q;
   logic [3:0]  pin_o_q;
   logic [3:0]  pin_oe_q;

   ////////////////////////////////////////////////////////////////////////
   // Register port

   wire wr_ctrl = reg_wr && (reg_addr == rx_bus_pkg::REG_CTRL);
   wire wr_sar  = reg_wr && (reg_addr == rx_bus_pkg::REG_SAR_WR);
   wire wr_clr  = reg_wr && (reg_addr == rx_bus_pkg::REG_CLEAR);
   wire wr_en   = reg_wr && (reg_addr == rx_bus_pkg::REG_ENABLE);

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (reg_addr)
         rx_bus_pkg::REG_CTRL:   rd_mux = {27'h0, ctrl_q};
         rx_bus_pkg::REG_SAR_WR: rd_mux = {22'h0, sar_wr_q};
         rx_bus_pkg::REG_DATA:   rd_mux = {19'h0, data_q};
         rx_bus_pkg::REG_SAR_RD: rd_mux = {21'h0, sar_rd_q};
         rx_bus_pkg::REG_STATUS: rd_mux = {28'h0, status_q};
         rx_bus_pkg::REG_ENABLE: rd_mux = {28'h0, enable_q};
         default:                rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q   <= rx_bus_pkg::CTRL_RST;
         sar_wr_q <= '0;
         enable_q <= '0;
         rdata_q  <= '0;
      end else begin
         ctrl_q   <= wr_ctrl ? reg_wdata[4:0] : ctrl_q;
         sar_wr_q <= wr_sar ? reg_wdata[9:0] : sar_wr_q;
         enable_q <= wr_en ? reg_wdata[3:0] : enable_q;
         rdata_q  <= reg_rd ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin sampling and interface clock

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end else begin
         sync1_q <= {link.bus, link.pin, 1'b0};
         sync2_q <= sync1_q;
      end
   end

   wire [9:0] bus_s  = sync2_q[14:5];
   wire [3:0] pin_s  = sync2_q[4:1];
   wire       rise   = pin_s[rx_bus_pkg::PIN_CLK] & ~lclk_prev_q;
   wire       wrap   = (div_cnt_q == 8'(rx_bus_pkg::LINK_HALF_CYC - 1));
   wire       en     = ctrl_q[rx_bus_pkg::CTRL_BUS_EN];
   wire       acc    = ctrl_q[rx_bus_pkg::CTRL_ACCESS];
   wire       rd_dir = ctrl_q[rx_bus_pkg::CTRL_READ];

   always_ff @(posedge clk) begin
      if (rst) begin
         lclk_prev_q <= 1'b1;
         div_cnt_q   <= '0;
         lclk_q      <= 1'b0;
      end else begin
         lclk_prev_q <= pin_s[rx_bus_pkg::PIN_CLK];
         div_cnt_q   <= wrap ? 8'h00 : div_cnt_q + 8'h01;
         lclk_q      <= wrap ? ~lclk_q : lclk_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive: direction and mode during address register access

   wire drv_wr = en & acc & ~rd_dir;

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_o_q  <= '0;
         bus_oe_q <= 1'b0;
         pin_o_q  <= '0;
         pin_oe_q <= '0;
      end else begin
         bus_o_q  <= sar_wr_q;
         bus_oe_q <= drv_wr;
         pin_o_q  <= {lclk_q, ctrl_q[rx_bus_pkg::CTRL_UNICAST], 1'b0, rd_dir};
         pin_oe_q <= {ctrl_q[rx_bus_pkg::CTRL_FIFO_ON], drv_wr, 1'b0, acc};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture on interface clock rise and sticky events

   wire take = rise & en;
   wire [3:0] ev_set;
   assign ev_set[rx_bus_pkg::EV_WORD]   = take & ~acc;
   assign ev_set[rx_bus_pkg::EV_VIOL]   = take & ~acc & pin_s[rx_bus_pkg::PIN_VIOL];
   assign ev_set[rx_bus_pkg::EV_SAR_RD] = take & acc & rd_dir;
   assign ev_set[rx_bus_pkg::EV_SAR_WR] = take & acc & ~rd_dir;

   wire [3:0] clr_mask = wr_clr ? reg_wdata[3:0] : 4'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         data_q   <= '0;
         sar_rd_q <= '0;
         status_q <= '0;
         irq_q    <= 1'b0;
      end else begin
         if (ev_set[rx_bus_pkg::EV_WORD]) begin
            // Bit nine is ignored by software in decoded eight-bit mode
            data_q <= {pin_s[2:0], bus_s};
         end
         if (ev_set[rx_bus_pkg::EV_SAR_RD]) begin
            sar_rd_q <= {pin_s[rx_bus_pkg::PIN_SD], bus_s};
         end
         status_q <= (status_q & ~clr_mask) | ev_set;
         irq_q    <= |(((status_q & ~clr_mask) | ev_set) & enable_q);
      end
   end

   assign link.h_bus_o    = bus_o_q;
   assign link.h_bus_oe   = bus_oe_q;
   assign link.h_pin_o    = pin_o_q;
   assign link.h_pin_oe   = pin_oe_q;
   assign link.bus_en     = ctrl_q[rx_bus_pkg::CTRL_BUS_EN];
   assign link.reg_access = ctrl_q[rx_bus_pkg::CTRL_ACCESS];
   assign reg_rdata       = rdata_q;
   assign irq             = irq_q;
endmodule

//--- logic/rx_output_mux.sv
/*
 Device end of the receive host bus: maps decoded or raw characters,
 flags and self-test mismatches onto the bus, and serves serial address
 register reads and writes. Makes the interface clock when the FIFO is
 bypassed. Assumes user-side inputs are on clk; link pins are not.
*/
// Chosen here: the strobed register port and the register addresses.
// Operation
// - Decoded ten-bit mode: bit nine is MSB
// - Bypass: bit nine is raw bit ten
// - FIFO and decoder: three flags drive outputs
// - FIFO bypassed: violation flag marks code violation
// - FIFO bypassed: special flag marks special code
// - Bypass ten-bit: bit ten is raw eleventh
// - Bypass eight-bit: bits ten, eleven low
// - Bypass ten-bit: bit eleven is raw MSB
// - Self-test: violation line reports mismatches
// - Violation line picks address register direction
// - Special line picks unicast or multicast
// - Bypass: special flag pin unused
// - Drive after, sample on, interface clock rise
// - Bypass: bits seven to zero raw low
// - Bypass: bit eight is raw ninth
// - Bus enable gates address register access
// - FIFO bypassed: device outputs interface clock
`timescale 1ns/1ps
module rx_output_mux #(
   parameter logic [23:0] SPECIAL_LUT = 24'h000000
) (
   input  wire logic        clk,
   input  wire logic        rst,
   rx_link_if.device_end    link,
   input  wire logic        codec_bypass_n,
   input  wire logic        char_width_select,
   input  wire logic        fifo_bypass_n,
   input  wire logic        rx_selftest_enable_n,
   input  wire logic        device_address_match,
   input  wire logic [11:0] rx_char,
   input  wire logic        rx_special,
   input  wire logic        rx_code_violation,
   input  wire logic [2:0]  rx_special_kind,
   input  wire logic        rx_bist_mismatch,
   output logic      [9:0]  sar_addr,
   output logic             sar_unicast,
   output logic             rx_char_taken
);
   localparam int SYNC_W = 16;
   // Idle pull levels, so no false interface clock edge follows reset
   localparam logic [SYNC_W-1:0] SYNC_RST = {10'h000, rx_bus_pkg::PIN_PULL, 2'b00};

   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic              lclk_prev_q;
   logic [7:0]        div_cnt_q;
   logic              lclk_q;
   logic [9:0]        bus_q;
   logic              bus_oe_q;
   logic [2:0]        pin_q;
   logic [2:0]        pin_oe_q;
   logic [9:0]        sar_q;
   logic              unicast_q;
   logic              taken_q;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and interface clock edge

   wire [SYNC_W-1:0] pins_raw = {link.bus, link.pin, link.bus_en, link.reg_access};

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   wire [9:0] bus_s    = sync2_q[15:6];
   wire       viol_s   = sync2_q[2 + rx_bus_pkg::PIN_VIOL];
   wire       sd_s     = sync2_q[2 + rx_bus_pkg::PIN_SD];
   wire       lclk_s   = sync2_q[2 + rx_bus_pkg::PIN_CLK];
   wire       bus_en_s = sync2_q[1];
   wire       access_s = sync2_q[0];
   wire       rise     = lclk_s & ~lclk_prev_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         lclk_prev_q <= 1'b1;
      end else begin
         lclk_prev_q <= lclk_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interface clock divider, driven out only with the FIFO bypassed

   wire div_wrap = (div_cnt_q == 8'(rx_bus_pkg::LINK_HALF_CYC - 1));

   always_ff @(posedge clk) begin
      if (rst) begin
         div_cnt_q <= '0;
         lclk_q    <= 1'b0;
      end else begin
         div_cnt_q <= div_wrap ? 8'h00 : div_cnt_q + 8'h01;
         lclk_q    <= div_wrap ? ~lclk_q : lclk_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Access mode

   wire byp    = ~codec_bypass_n;
   wire w8     = char_width_select;
   wire fifo   = fifo_bypass_n;
   wire bist   = ~rx_selftest_enable_n;
   wire sel    = bus_en_s & device_address_match;

   rx_bus_pkg::access_mode_t mode;
   assign mode = !sel      ? rx_bus_pkg::MODE_IDLE
               : !access_s ? rx_bus_pkg::MODE_DATA
               : viol_s    ? rx_bus_pkg::MODE_SAR_RD
               :             rx_bus_pkg::MODE_SAR_WR;

   ////////////////////////////////////////////////////////////////////////
   // Data path mapping

   wire [2:0] lut_flags = SPECIAL_LUT[3*rx_special_kind +: 3];

   // Raw bits 9:0 in bypass, decoded character otherwise
   wire [9:0] data_bus = rx_char[9:0];

   wire viol_data = bist ? rx_bist_mismatch
                  : byp  ? (w8 ? 1'b0 : rx_char[10])
                  : fifo ? lut_flags[2]
                  :        rx_code_violation;
   wire soc_data  = byp  ? (w8 ? 1'b0 : rx_char[11])
                  : fifo ? lut_flags[1]
                  :        1'b0;
   wire sd_data   = fifo ? lut_flags[0] : rx_special;
   wire sd_oe_dat = ~byp;

   logic [9:0] bus_d;
   logic       bus_oe_d;
   logic [2:0] pin_d;
   logic [2:0] pin_oe_d;

   always_comb begin
      bus_d    = '0;
      bus_oe_d = 1'b0;
      pin_d    = '0;
      pin_oe_d = '0;
      unique case (mode)
         rx_bus_pkg::MODE_IDLE: begin
            bus_oe_d = 1'b0;
         end
         rx_bus_pkg::MODE_DATA: begin
            bus_d    = data_bus;
            bus_oe_d = 1'b1;
            pin_d    = {sd_data, soc_data, viol_data};
            pin_oe_d = {sd_oe_dat, 2'b11};
         end
         rx_bus_pkg::MODE_SAR_RD: begin
            bus_d    = sar_q;
            bus_oe_d = 1'b1;
            pin_d    = {unicast_q, 2'b00};
            pin_oe_d = 3'b100;
         end
         rx_bus_pkg::MODE_SAR_WR: begin
            bus_oe_d = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs change only after a detected interface clock rise

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_q    <= '0;
         bus_oe_q <= 1'b0;
         pin_q    <= '0;
         pin_oe_q <= '0;
      end else if (rise) begin
         bus_q    <= bus_d;
         bus_oe_q <= bus_oe_d;
         pin_q    <= pin_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial address register, written on a rise

   wire sar_write = rise && (mode == rx_bus_pkg::MODE_SAR_WR);

   always_ff @(posedge clk) begin
      if (rst) begin
         sar_q     <= '0;
         unicast_q <= 1'b0;
      end else if (sar_write) begin
         sar_q     <= bus_s;
         unicast_q <= sd_s;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         taken_q <= 1'b0;
      end else begin
         taken_q <= rise && (mode == rx_bus_pkg::MODE_DATA);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link and user outputs

   assign link.d_bus_o  = bus_q;
   assign link.d_bus_oe = bus_oe_q;
   assign link.d_pin_o  = {lclk_q, pin_q};
   assign link.d_pin_oe = {~fifo, pin_oe_q};
   assign sar_addr      = sar_q;
   assign sar_unicast   = unicast_q;
   assign rx_char_taken = taken_q;
endmodule

//--- pkg/rx_bus_pkg.sv
/*
 Shared constants for the receive host-bus link: pin indices, timing,
 controller register map, event bits and access modes.
 Assumes a 100 MHz system clock on both ends.
*/
package rx_bus_pkg;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int LINK_PERIOD_NS = 125;
   localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int BUS_W          = 10;
   // Shared flag/clock pin indices
   localparam int PIN_VIOL = 0;
   localparam int PIN_SOC  = 1;
   localparam int PIN_SD   = 2;
   localparam int PIN_CLK  = 3;
   localparam logic [3:0] PIN_PULL = 4'h9;
   // Controller register offsets
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_SAR_WR = 4'h1;
   localparam logic [3:0] REG_DATA   = 4'h2;
   localparam logic [3:0] REG_SAR_RD = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CLEAR  = 4'h5;
   localparam logic [3:0] REG_ENABLE = 4'h6;
   // Control fields
   localparam int CTRL_W         = 5;
   localparam int CTRL_BUS_EN    = 0;
   localparam int CTRL_ACCESS    = 1;
   localparam int CTRL_READ      = 2;
   localparam int CTRL_UNICAST   = 3;
   localparam int CTRL_FIFO_ON   = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // Events
   localparam int EV_W      = 4;
   localparam int EV_WORD   = 0;
   localparam int EV_VIOL   = 1;
   localparam int EV_SAR_RD = 2;
   localparam int EV_SAR_WR = 3;
   typedef enum logic [1:0] {
      MODE_IDLE   = 2'b00,
      MODE_DATA   = 2'b01,
      MODE_SAR_WR = 2'b10,
      MODE_SAR_RD = 2'b11
   } access_mode_t;
endpackage

//--- pkg/rx_link_if.sv
/*
 Receive bus link between the device end and the host end.
 Each shared pin has an output and enable per end; the wire level is
 resolved here, with pull-ups on the violation and clock lines.
*/
`timescale 1ns/1ps
interface rx_link_if;
   logic [9:0] d_bus_o;
   logic       d_bus_oe;
   logic [9:0] h_bus_o;
   logic       h_bus_oe;
   logic [9:0] bus;
   logic [3:0] d_pin_o;
   logic [3:0] d_pin_oe;
   logic [3:0] h_pin_o;
   logic [3:0] h_pin_oe;
   logic [3:0] pin;
   logic       bus_en;
   logic       reg_access;

   assign bus = d_bus_oe ? d_bus_o : (h_bus_oe ? h_bus_o : '0);
   for (genvar i = 0; i < 4; i++) begin : g_pin
      assign pin[i] = d_pin_oe[i] ? d_pin_o[i]
                    : (h_pin_oe[i] ? h_pin_o[i] : rx_bus_pkg::PIN_PULL[i]);
   end

   modport device_end (
      output d_bus_o, d_bus_oe, d_pin_o, d_pin_oe,
      input  bus, pin, bus_en, reg_access
   );
   modport host_end (
      output h_bus_o, h_bus_oe, h_pin_o, h_pin_oe, bus_en, reg_access,
      input  bus, pin
   );
endinterface

//--- testbench/receive_output_bus_mux_bench.sv
/*
 Bench for the receive bus: device end and host end joined by the link.
 Assumes the host register map and event bits of the shared package.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", nm, (exp), (got)); end end
module receive_output_bus_mux_bench;
   localparam logic [23:0] LUT = 24'h000888;
   logic        clk, rst, codec_bypass_n, char_width_select, fifo_bypass_n;
   logic        rx_selftest_enable_n, device_address_match, rx_special, rx_code_violation;
   logic        rx_bist_mismatch, sar_unicast, rx_char_taken, reg_wr, reg_rd, irq;
   logic [11:0] rx_char;
   logic [2:0]  rx_special_kind;
   logic [9:0]  sar_addr;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   int          mismatches = 0;
   int          n_compared = 0;
   ////////////////////////////////////////////////////////////////////////////
   rx_link_if rx_link_if_i ();
   rx_output_mux #(.SPECIAL_LUT(LUT)) rx_output_mux_i (.clk(clk), .rst(rst),
      .link(rx_link_if_i.device_end), .codec_bypass_n(codec_bypass_n),
      .char_width_select(char_width_select), .fifo_bypass_n(fifo_bypass_n),
      .rx_selftest_enable_n(rx_selftest_enable_n), .device_address_match(device_address_match),
      .rx_char(rx_char), .rx_special(rx_special), .rx_code_violation(rx_code_violation),
      .rx_special_kind(rx_special_kind), .rx_bist_mismatch(rx_bist_mismatch),
      .sar_addr(sar_addr), .sar_unicast(sar_unicast), .rx_char_taken(rx_char_taken));
   rx_bus_host rx_bus_host_i (.clk(clk), .rst(rst), .link(rx_link_if_i.host_end),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));
   rx_link_chk rx_link_chk_i (.clk(clk), .rst(rst), .pin(rx_link_if_i.pin),
      .bus_en(rx_link_if_i.bus_en), .reg_access(rx_link_if_i.reg_access),
      .d_bus_o(rx_link_if_i.d_bus_o), .d_bus_oe(rx_link_if_i.d_bus_oe),
      .d_pin_oe(rx_link_if_i.d_pin_oe), .h_bus_oe(rx_link_if_i.h_bus_oe),
      .h_pin_o(rx_link_if_i.h_pin_o), .h_pin_oe(rx_link_if_i.h_pin_oe));
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic poll(input int b);
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < 300 && v[b] !== 1'b1; i++) rd(rx_bus_pkg::REG_STATUS, v);
      `CHK("status_event", 1'b1, v[b])
   endtask
   // Three clear-and-wait rounds: the host captures what the device latched a period before
   task automatic fresh(input int b);
      repeat (3) begin
         wr(rx_bus_pkg::REG_CLEAR, 32'hf);
         poll(b);
      end
   endtask
   // Link clock ownership is handed over with the bus disabled in between
   task automatic mode(input logic fbn, input logic cbn, input logic [4:0] c);
      wr(rx_bus_pkg::REG_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      fifo_bypass_n <= fbn; codec_bypass_n <= cbn;
      repeat (4) @(posedge clk);
      wr(rx_bus_pkg::REG_CTRL, {27'h0, c});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_sar;
      logic [31:0] v;
      wr(rx_bus_pkg::REG_SAR_WR, 32'h2a5);
      mode(1'b1, 1'b1, 5'h1b);
      fresh(3);
      `CHK("sar_addr", 10'h2a5, sar_addr)
      `CHK("sar_unicast", 1'b1, sar_unicast)
      wr(rx_bus_pkg::REG_SAR_WR, 32'h15a);
      wr(rx_bus_pkg::REG_CTRL, 32'h13);
      fresh(3);
      `CHK("sar_multicast", 1'b0, sar_unicast)
      // Bus disabled first, so the new address never meets an enabled device
      wr(rx_bus_pkg::REG_CTRL, 32'h12);
      wr(rx_bus_pkg::REG_SAR_WR, 32'h0ff);
      repeat (60) @(posedge clk);
      wr(rx_bus_pkg::REG_CLEAR, 32'hf);
      repeat (40) @(posedge clk);
      rd(rx_bus_pkg::REG_STATUS, v);
      `CHK("gated_write_event", 1'b0, v[3])
      `CHK("gated_sar_addr", 10'h15a, sar_addr)
      wr(rx_bus_pkg::REG_CTRL, 32'h17);
      fresh(2);
      rd(rx_bus_pkg::REG_SAR_RD, v);
      `CHK("sar_readback", 11'h15a, v[10:0])
   endtask
   task automatic t_raw(input logic w, input logic [12:0] exp);
      logic [31:0] v;
      @(posedge clk);
      char_width_select <= w; rx_char <= 12'hb5a; rx_special <= 1'b1;
      mode(1'b0, 1'b0, 5'h01);
      fresh(0);
      rd(rx_bus_pkg::REG_DATA, v);
      `CHK("raw_word", exp, v[12:0])
   endtask
   task automatic t_dec;
      logic [31:0] v;
      @(posedge clk);
      char_width_select <= 1'b0; rx_char <= 12'h2bc; rx_code_violation <= 1'b1;
      mode(1'b0, 1'b1, 5'h01);
      fresh(0);
      rd(rx_bus_pkg::REG_DATA, v);
      `CHK("decoded_word", 13'h16bc, v[12:0])
      for (int i = 0; i < 40 && rx_char_taken !== 1'b1; i++) @(posedge clk);
      `CHK("char_taken", 1'b1, rx_char_taken)
      @(posedge clk);
      `CHK("char_taken_pulse", 1'b0, rx_char_taken)
      rd(rx_bus_pkg::REG_STATUS, v);
      `CHK("violation_event", 1'b1, v[1])
      @(posedge clk);
      rx_char <= 12'h011; rx_special <= 1'b0; rx_code_violation <= 1'b0;
      rx_selftest_enable_n <= 1'b0; rx_bist_mismatch <= 1'b1;
      fresh(0);
      rd(rx_bus_pkg::REG_DATA, v);
      `CHK("selftest_miss", 13'h0411, v[12:0])
      @(posedge clk);
      rx_bist_mismatch <= 1'b0;
      fresh(0);
      rd(rx_bus_pkg::REG_DATA, v);
      `CHK("selftest_match", 13'h0011, v[12:0])
      @(posedge clk);
      rx_selftest_enable_n <= 1'b1;
      device_address_match <= 1'b0;
      fresh(0);
      rd(rx_bus_pkg::REG_DATA, v);
      `CHK("deselected_word", 13'h0400, v[12:0])
      @(posedge clk);
      device_address_match <= 1'b1;
   endtask
   task automatic t_regs;
      logic [31:0] v;
      wr(rx_bus_pkg::REG_ENABLE, 32'h1);
      repeat (3) @(posedge clk);
      `CHK("irq_raised", 1'b1, irq)
      wr(rx_bus_pkg::REG_ENABLE, 32'h0);
      repeat (3) @(posedge clk);
      `CHK("irq_masked", 1'b0, irq)
      wr(rx_bus_pkg::REG_CTRL, 32'h0);
      repeat (40) @(posedge clk);
      wr(rx_bus_pkg::REG_CLEAR, 32'hf);
      wr(rx_bus_pkg::REG_ENABLE, 32'h1);
      rd(rx_bus_pkg::REG_STATUS, v);
      `CHK("status_cleared", 4'h0, v[3:0])
      `CHK("irq_cleared", 1'b0, irq)
      rd(4'hf, v);
      `CHK("unmapped_read", 32'h0, v)
      rd(rx_bus_pkg::REG_CLEAR, v);
      `CHK("clear_reads_zero", 32'h0, v)
   endtask
   task automatic t_lut;
      logic [31:0] v;
      mode(1'b1, 1'b1, 5'h11);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         rx_special_kind <= k[2:0]; rx_special <= (k != 0); rx_char <= 12'h07c;
         fresh(0);
         rd(rx_bus_pkg::REG_DATA, v);
         `CHK("special_flags", {LUT[3*k], LUT[3*k+1], LUT[3*k+2], 10'h07c}, v[12:0])
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      close_out;
   end
   initial begin
      rst = 1'b1; codec_bypass_n = 1'b1; char_width_select = 1'b0; fifo_bypass_n = 1'b1;
      rx_selftest_enable_n = 1'b1; device_address_match = 1'b1; rx_char = 12'h000;
      rx_special = 1'b0; rx_code_violation = 1'b0; rx_special_kind = 3'h0;
      rx_bist_mismatch = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_sar;
      t_raw(1'b0, 13'h0b5a);
      t_raw(1'b1, 13'h035a);
      t_dec;
      t_regs;
      t_lut;
      close_out;
   end
endmodule

//--- testbench/rx_link_chk.sv
/*
 Checker for the receive bus link between the device and host ends.
 Assumes it watches the resolved link pins and each end's drive outputs and enables on the 100 MHz clock.
*/
`timescale 1ns/1ps
module rx_link_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [3:0] pin,
   input wire logic       bus_en,
   input wire logic       reg_access,
   input wire logic [9:0] d_bus_o,
   input wire logic       d_bus_oe,
   input wire logic [3:0] d_pin_oe,
   input wire logic       h_bus_oe,
   input wire logic [3:0] h_pin_o,
   input wire logic [3:0] h_pin_oe
);
   ////////////////////////////////////////////////////////////////////////////
   logic [5:0] off_q;
   logic [5:0] off_d;
   logic [5:0] wr_q;
   logic [5:0] wr_d;
   logic [5:0] since_q;
   logic [5:0] since_d;
   logic       clk_prev_q;
   wire        rise = pin[3] && !clk_prev_q;
   // Saturating counts of quiet, write-direction and time since a clock rise
   assign off_d   = bus_en ? 6'h00 : ((off_q == 6'h3f) ? off_q : off_q + 6'h01);
   assign wr_d    = !(reg_access && !pin[0]) ? 6'h00
                  : ((wr_q == 6'h3f) ? wr_q : wr_q + 6'h01);
   assign since_d = rise ? 6'h00 : ((since_q == 6'h3f) ? since_q : since_q + 6'h01);
   always_ff @(posedge clk) begin
      off_q      <= rst ? 6'h00 : off_d;
      wr_q       <= rst ? 6'h00 : wr_d;
      since_q    <= rst ? 6'h3f : since_d;
      clk_prev_q <= rst ? 1'b1 : pin[3];
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   bus_no_clash_a: assert property (!(d_bus_oe && h_bus_oe))
      else $error("both ends drive the data bus");
   viol_no_clash_a: assert property (!(d_pin_oe[0] && h_pin_oe[0]))
      else $error("both ends drive the violation line");
   sd_no_clash_a: assert property (!(d_pin_oe[2] && h_pin_oe[2]))
      else $error("both ends drive the special line");
   clk_no_clash_a: assert property (!(d_pin_oe[3] && h_pin_oe[3]))
      else $error("both ends drive the interface clock");
   disabled_quiet_a: assert property (off_q >= 6'h1e |-> !d_bus_oe && d_pin_oe[2:0] == 3'h0)
      else $error("device drives while bus disabled");
   write_dir_a: assert property (wr_q >= 6'h1e |-> !d_bus_oe && !d_pin_oe[2])
      else $error("device drives during address write");
   read_dir_a: assert property (reg_access && h_pin_oe[0] && h_pin_o[0] |-> !h_bus_oe)
      else $error("host drives bus during address read");
   after_rise_a: assert property ($changed(d_bus_o) |-> since_q <= 6'h08)
      else $error("device bus changed away from a clock rise");
   cover property (reg_access && !pin[0] && h_bus_oe);
   cover property (reg_access && pin[0] && d_bus_oe);
   cover property (bus_en && !reg_access && d_bus_oe);
endmodule
